// >>> verilog/irqh_pkg.sv
package irqh_pkg;
  localparam int NSRC = 8;
  localparam int SRC_W = 3;
  localparam int ADDR_W = 16;
  localparam int EV_W = 3;

  // register byte offsets
  localparam logic [7:0] OFF_INTERRUPT_ENABLE_REGISTER = 8'h00;
  localparam logic [7:0] OFF_EIE   = 8'h04;
  localparam logic [7:0] OFF_PRIO  = 8'h08;
  localparam logic [7:0] OFF_PEND  = 8'h0C;
  localparam logic [7:0] OFF_PCLR  = 8'h10;
  localparam logic [7:0] OFF_AUTO  = 8'h14;
  localparam logic [7:0] OFF_STATE = 8'h18;
  localparam logic [7:0] OFF_ISTAT = 8'h1C;
  localparam logic [7:0] OFF_ICLR  = 8'h20;
  localparam logic [7:0] OFF_IEN   = 8'h24;

  // field positions
  localparam int GEN_BIT   = 7;
  localparam int EV_VECTOR = 0;
  localparam int EV_RETURN = 1;
  localparam int EV_NEST   = 2;

  // reset values
  localparam logic [7:0]      INTERRUPT_ENABLE_REGISTER_RST = 8'h00;
  localparam logic [7:0]      PRIO_RST = 8'h00;
  localparam logic [7:0]      AUTO_RST = 8'h03;
  localparam logic [EV_W-1:0] EV_RST   = 3'h0;

  // vector table layout
  localparam logic [ADDR_W-1:0] VEC_BASE   = 16'h0003;
  localparam logic [ADDR_W-1:0] VEC_STRIDE = 16'h0008;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_LO   = 4'h2,
    ST_HI   = 4'h4,
    ST_BOTH = 4'h8
  } irqh_state_t;

  typedef struct packed {
    logic              stb;
    logic [SRC_W-1:0]  src;
    logic              level;
    logic [ADDR_W-1:0] addr;
  } irqh_call_t;

  typedef struct packed {
    logic             found;
    logic [SRC_W-1:0] src;
    logic             level;
  } irqh_pick_t;

  function automatic logic [ADDR_W-1:0] vector_of(input logic [SRC_W-1:0] src);
    vector_of = VEC_BASE + 16'(16'(src) * VEC_STRIDE);
  endfunction

  // lowest set index wins; msb of result flags a hit
  function automatic logic [SRC_W:0] first_set(input logic [NSRC-1:0] m);
    first_set = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (m[i]) begin
        first_set = {1'b1, SRC_W'(i)};
      end
    end
  endfunction
endpackage

// >>> verilog/irqh_arbiter.sv
`timescale 1ns/1ps
module irqh_arbiter (
  // request state
  input  wire logic [irqh_pkg::NSRC-1:0] i_pend,
  input  wire logic [irqh_pkg::NSRC-1:0] i_en,
  input  wire logic                      i_gen,
  input  wire logic [irqh_pkg::NSRC-1:0] i_prio,
  // nesting permission
  input  wire logic                      i_allow_hi,
  input  wire logic                      i_allow_lo,
  // winner
  output irqh_pkg::irqh_pick_t           o_pick
);
  wire logic [irqh_pkg::NSRC-1:0] live;
  wire logic [irqh_pkg::NSRC-1:0] hi_req;
  wire logic [irqh_pkg::NSRC-1:0] lo_req;
  wire logic [irqh_pkg::SRC_W:0]  hi_win;
  wire logic [irqh_pkg::SRC_W:0]  lo_win;
  wire logic                      use_hi;
  wire logic                      use_lo;

  assign live   = i_pend & i_en & {irqh_pkg::NSRC{i_gen}};
  assign hi_req = live & i_prio;
  assign lo_req = live & ~i_prio;
  assign hi_win = irqh_pkg::first_set(hi_req);
  assign lo_win = irqh_pkg::first_set(lo_req);
  assign use_hi = hi_win[irqh_pkg::SRC_W] & i_allow_hi;
  assign use_lo = lo_win[irqh_pkg::SRC_W] & i_allow_lo & ~use_hi;

  assign o_pick.found = use_hi | use_lo;
  assign o_pick.level = use_hi;
  assign o_pick.src   = use_hi ? hi_win[irqh_pkg::SRC_W-1:0] : lo_win[irqh_pkg::SRC_W-1:0];
endmodule

// >>> verilog/irqh_ctrl.sv
// Operation
// - eight sources, each set to high or low priority by one bit of the priority register.
// - a peripheral pulse or a synchronised pin rising edge sets that source's pending flag.
// - a CPU request stands only while pending, own enable and global enable are all set.
// - a request is taken only at an instruction boundary and answered by a call strobe with the vector.
// - every source has a fixed vector address, base plus source index times stride.
// - the return strobe closes the innermost active service level so the CPU resumes where it left.
// - pending flags are set whatever the enables hold; disabled flags raise nothing.
// - sources marked auto-clear lose their flag on vectoring, others keep it until software clears it.
// - a flag still set after a return is taken again at the boundary after one more instruction.
// - each source has an enable bit, sources 0-6 in the enable register and source 7 in the extended one.
// - individual enables count only while bit 7 of the enable register is 1.
// - a 0 in the global enable blocks every source.
// - flags raised while globally disabled stay pending and are served once enabled again.
// - software writing 1 to a pending bit acts as a hardware event.
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module irqh_ctrl (
  // clock and reset
  input  wire logic                           I_REF_CLK,
  input  wire logic                           I_RST,
  // wishbone slave
  input  wire logic                           I_WB_CYC,
  input  wire logic                           I_WB_STB,
  input  wire logic                           I_WB_WE,
  input  wire logic [7:0]                     I_WB_ADR,
  input  wire logic [3:0]                     I_WB_SEL,
  input  wire logic [31:0]                    I_WB_DAT,
  output logic      [31:0]                    O_WB_DAT,
  output logic                                O_WB_ACK,
  // interrupt sources
  input  wire logic [1:0]                     I_PIN_IRQ,
  input  wire logic [5:0]                     I_PERIPH_EVENT,
  // cpu sequencer
  input  wire logic                           I_INSTR_DONE,
  input  wire logic                           I_RETURN_FROM_INTERRUPT,
  output logic                                O_CPU_REQ,
  output irqh_pkg::irqh_call_t                O_CALL,
  // block interrupt
  output logic                                O_IRQ
);
  logic [7:0]                  interrupt_enable_register;
  logic                        eie;
  logic [7:0]                  prio;
  logic [irqh_pkg::NSRC-1:0]   pend;
  logic [irqh_pkg::NSRC-1:0]   auto_clr;
  logic [irqh_pkg::EV_W-1:0]   ev_stat;
  logic [irqh_pkg::EV_W-1:0]   ev_en;
  irqh_pkg::irqh_state_t       state;
  irqh_pkg::irqh_state_t       next_state;
  logic [1:0]                  pin_s1;
  logic [1:0]                  pin_s2;
  logic [1:0]                  pin_s3;
  irqh_pkg::irqh_pick_t        pick;

  wire logic                        acc;
  wire logic                        wr;
  wire logic [7:0]                  wd;
  wire logic                        wr_interrupt_enable_register;
  wire logic                        wr_eie;
  wire logic                        wr_prio;
  wire logic                        wr_pend;
  wire logic                        wr_pclr;
  wire logic                        wr_auto;
  wire logic                        wr_iclr;
  wire logic                        wr_ien;
  wire logic [irqh_pkg::NSRC-1:0]   en;
  wire logic                        gen;
  wire logic [irqh_pkg::NSRC-1:0]   hw_ev;
  wire logic [irqh_pkg::NSRC-1:0]   sw_set;
  wire logic [irqh_pkg::NSRC-1:0]   sw_clr;
  wire logic [irqh_pkg::NSRC-1:0]   auto_hit;
  wire logic [irqh_pkg::NSRC-1:0]   next_pend;
  wire logic                        allow_hi;
  wire logic                        allow_lo;
  wire logic                        take;
  wire logic [irqh_pkg::EV_W-1:0]   ev;
  wire logic [irqh_pkg::EV_W-1:0]   next_ev_stat;
  wire logic [31:0]                 rd_word;

  // bus decode, write lands on the acking edge
  assign acc     = I_WB_CYC & I_WB_STB;
  assign wr      = acc & I_WB_WE & O_WB_ACK & I_WB_SEL[0];
  assign wd      = I_WB_DAT[7:0];
  assign wr_interrupt_enable_register = wr & (I_WB_ADR == irqh_pkg::OFF_INTERRUPT_ENABLE_REGISTER);
  assign wr_eie  = wr & (I_WB_ADR == irqh_pkg::OFF_EIE);
  assign wr_prio = wr & (I_WB_ADR == irqh_pkg::OFF_PRIO);
  assign wr_pend = wr & (I_WB_ADR == irqh_pkg::OFF_PEND);
  assign wr_pclr = wr & (I_WB_ADR == irqh_pkg::OFF_PCLR);
  assign wr_auto = wr & (I_WB_ADR == irqh_pkg::OFF_AUTO);
  assign wr_iclr = wr & (I_WB_ADR == irqh_pkg::OFF_ICLR);
  assign wr_ien  = wr & (I_WB_ADR == irqh_pkg::OFF_IEN);

  assign rd_word = (I_WB_ADR == irqh_pkg::OFF_INTERRUPT_ENABLE_REGISTER) ? {24'h000000, interrupt_enable_register} :
                   (I_WB_ADR == irqh_pkg::OFF_EIE)   ? {31'h0000000, eie} :
                   (I_WB_ADR == irqh_pkg::OFF_PRIO)  ? {24'h000000, prio} :
                   (I_WB_ADR == irqh_pkg::OFF_PEND)  ? {24'h000000, pend} :
                   (I_WB_ADR == irqh_pkg::OFF_AUTO)  ? {24'h000000, auto_clr} :
                   (I_WB_ADR == irqh_pkg::OFF_STATE) ? {28'h0000000, state} :
                   (I_WB_ADR == irqh_pkg::OFF_ISTAT) ? {29'h0000000, ev_stat} :
                   (I_WB_ADR == irqh_pkg::OFF_IEN)   ? {29'h0000000, ev_en} : 32'h00000000;

  assign en  = {eie, interrupt_enable_register[6:0]};
  assign gen = interrupt_enable_register[irqh_pkg::GEN_BIT];

  // pin edges after two sync stages
  assign hw_ev    = {I_PERIPH_EVENT, pin_s2 & ~pin_s3};
  assign sw_set   = wr_pend ? wd : 8'h00;
  assign sw_clr   = wr_pclr ? wd : 8'h00;
  assign auto_hit = take ? (auto_clr & (8'h01 << pick.src)) : 8'h00;
  // set wins over any clear in the same cycle
  assign next_pend = (pend & ~sw_clr & ~auto_hit) | hw_ev | sw_set;

  assign allow_hi = (state == irqh_pkg::ST_IDLE) | (state == irqh_pkg::ST_LO);
  assign allow_lo = (state == irqh_pkg::ST_IDLE);
  // no vectoring in the return's own boundary, so one more instruction runs
  assign take = I_INSTR_DONE & ~I_RETURN_FROM_INTERRUPT & pick.found;

  assign ev[irqh_pkg::EV_VECTOR] = take;
  assign ev[irqh_pkg::EV_RETURN] = I_RETURN_FROM_INTERRUPT;
  assign ev[irqh_pkg::EV_NEST]   = take & pick.level & (state == irqh_pkg::ST_LO);
  assign next_ev_stat = (ev_stat & ~(wr_iclr ? wd[irqh_pkg::EV_W-1:0] : 3'h0)) | ev;

  irqh_arbiter u_arb (
    .i_pend     (pend),
    .i_en       (en),
    .i_gen      (gen),
    .i_prio     (prio),
    .i_allow_hi (allow_hi),
    .i_allow_lo (allow_lo),
    .o_pick     (pick)
  );

  // service level tracking
  always_comb begin
    next_state = state;
    unique case (state)
      irqh_pkg::ST_IDLE: begin
        if (take) begin
          next_state = pick.level ? irqh_pkg::ST_HI : irqh_pkg::ST_LO;
        end
      end
      irqh_pkg::ST_LO: begin
        if (I_RETURN_FROM_INTERRUPT) begin
          next_state = irqh_pkg::ST_IDLE;
        end else if (take) begin
          next_state = irqh_pkg::ST_BOTH;
        end
      end
      irqh_pkg::ST_HI: begin
        if (I_RETURN_FROM_INTERRUPT) begin
          next_state = irqh_pkg::ST_IDLE;
        end
      end
      irqh_pkg::ST_BOTH: begin
        if (I_RETURN_FROM_INTERRUPT) begin
          next_state = irqh_pkg::ST_LO;
        end
      end
      default: next_state = irqh_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      pin_s1 <= 2'h0;
      pin_s2 <= 2'h0;
      pin_s3 <= 2'h0;
    end else begin
      pin_s1 <= I_PIN_IRQ;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h00000000;
    end else begin
      O_WB_ACK <= acc & ~O_WB_ACK;
      O_WB_DAT <= (acc & ~O_WB_ACK & ~I_WB_WE) ? rd_word : 32'h00000000;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      interrupt_enable_register <= irqh_pkg::INTERRUPT_ENABLE_REGISTER_RST;
      eie      <= 1'b0;
      prio     <= irqh_pkg::PRIO_RST;
      auto_clr <= irqh_pkg::AUTO_RST;
      ev_en    <= irqh_pkg::EV_RST;
    end else begin
      if (wr_interrupt_enable_register) interrupt_enable_register <= wd;
      if (wr_eie) eie <= wd[0];
      if (wr_prio) prio <= wd;
      if (wr_auto) auto_clr <= wd;
      if (wr_ien) ev_en <= wd[irqh_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      pend    <= 8'h00;
      state   <= irqh_pkg::ST_IDLE;
      ev_stat <= irqh_pkg::EV_RST;
      O_IRQ   <= 1'b0;
    end else begin
      pend    <= next_pend;
      state   <= next_state;
      ev_stat <= next_ev_stat;
      O_IRQ   <= |(next_ev_stat & ev_en);
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      O_CPU_REQ <= 1'b0;
      O_CALL    <= '0;
    end else begin
      O_CPU_REQ  <= pick.found;
      O_CALL.stb <= take;
      if (take) begin
        O_CALL.src   <= pick.src;
        O_CALL.level <= pick.level;
        O_CALL.addr  <= irqh_pkg::vector_of(pick.src);
      end
    end
  end

  // checks
  property p_hw_sets_pend;
    @(posedge I_REF_CLK) disable iff (I_RST)
      (|hw_ev) |=> ((pend & $past(hw_ev)) == $past(hw_ev));
  endproperty
  a_hw_sets_pend: assert property (p_hw_sets_pend) else $error("event did not set pending flag");

  property p_req_gated;
    @(posedge I_REF_CLK) disable iff (I_RST)
      O_CPU_REQ |-> ($past(gen) && (|($past(pend) & $past(en))));
  endproperty
  a_req_gated: assert property (p_req_gated) else $error("request without enabled pending flag");

  property p_call_at_boundary;
    @(posedge I_REF_CLK) disable iff (I_RST)
      O_CALL.stb |-> ($past(I_INSTR_DONE) && !$past(I_RETURN_FROM_INTERRUPT) && $past(pick.found));
  endproperty
  a_call_at_boundary: assert property (p_call_at_boundary) else $error("call outside a boundary");

  property p_vector_fixed;
    @(posedge I_REF_CLK) disable iff (I_RST)
      O_CALL.stb |-> (O_CALL.addr == irqh_pkg::VEC_BASE + 16'(16'(O_CALL.src) * irqh_pkg::VEC_STRIDE));
  endproperty
  a_vector_fixed: assert property (p_vector_fixed) else $error("wrong vector address");

  property p_return_defers;
    @(posedge I_REF_CLK) disable iff (I_RST)
      I_RETURN_FROM_INTERRUPT |=> !O_CALL.stb;
  endproperty
  a_return_defers: assert property (p_return_defers) else $error("vectored in return boundary");

  property p_global_off;
    @(posedge I_REF_CLK) disable iff (I_RST)
      !gen |=> !O_CPU_REQ;
  endproperty
  a_global_off: assert property (p_global_off) else $error("request while globally disabled");

  property p_pending_held;
    @(posedge I_REF_CLK) disable iff (I_RST)
      (!gen && !wr_pclr) |=> ((pend & $past(pend)) == $past(pend));
  endproperty
  a_pending_held: assert property (p_pending_held) else $error("pending flag lost while disabled");

  property p_sw_trigger;
    @(posedge I_REF_CLK) disable iff (I_RST)
      wr_pend |=> ((pend & $past(wd)) == $past(wd));
  endproperty
  a_sw_trigger: assert property (p_sw_trigger) else $error("software set not taken");

  property p_auto_clear;
    @(posedge I_REF_CLK) disable iff (I_RST)
      (|auto_hit && !(|(auto_hit & (hw_ev | sw_set)))) |=> !(|(pend & $past(auto_hit)));
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("auto-clear flag survived vectoring");

  property p_high_first;
    @(posedge I_REF_CLK) disable iff (I_RST)
      (O_CALL.stb && !O_CALL.level) |-> !(|($past(pend) & $past(en) & $past(prio)));
  endproperty
  a_high_first: assert property (p_high_first) else $error("low served over high");

  property p_return_pops;
    @(posedge I_REF_CLK) disable iff (I_RST)
      (I_RETURN_FROM_INTERRUPT && state == irqh_pkg::ST_BOTH) |=> (state == irqh_pkg::ST_LO);
  endproperty
  a_return_pops: assert property (p_return_pops) else $error("return did not close inner level");

  property p_low_only_idle;
    @(posedge I_REF_CLK) disable iff (I_RST)
      (O_CALL.stb && !O_CALL.level) |-> ($past(state) == irqh_pkg::ST_IDLE);
  endproperty
  a_low_only_idle: assert property (p_low_only_idle) else $error("low call inside a service level");

  property p_nest_hi_over_lo;
    @(posedge I_REF_CLK) disable iff (I_RST)
      (take && pick.level && state == irqh_pkg::ST_LO) |=> (state == irqh_pkg::ST_BOTH) ##0 O_CALL.stb;
  endproperty
  c_nest: cover property (p_nest_hi_over_lo);
  c_call: cover property (@(posedge I_REF_CLK) disable iff (I_RST) O_CALL.stb ##[1:50] I_RETURN_FROM_INTERRUPT);
  c_reenter: cover property (@(posedge I_REF_CLK) disable iff (I_RST) I_RETURN_FROM_INTERRUPT ##[1:20] O_CALL.stb);
endmodule

// >>> tb/irqh_cpu_model.sv
`timescale 1ns/1ps
module irqh_cpu_model (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // controls
  input  wire logic       i_call_stb,
  input  wire logic       i_hold,
  input  wire logic [1:0] i_gap,
  // sequencer outputs
  output logic            o_instr_done,
  output logic            o_return_from_interrupt
);
  logic [2:0] wait_cnt;
  logic [1:0] depth;
  logic [1:0] isr_cnt;
  logic       next_done;
  logic       next_return;
  // boundaries never back to back, so a call strobe never meets one
  assign next_done = (wait_cnt == 3'h0);
  // routine ends after three body instructions unless held
  assign next_return = next_done && depth != 2'h0 && !i_hold && isr_cnt == 2'h3 && !i_call_stb;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_instr_done <= 1'b0;
      o_return_from_interrupt <= 1'b0;
      wait_cnt     <= 3'h2;
      depth        <= 2'h0;
      isr_cnt      <= 2'h0;
    end else begin
      o_instr_done <= next_done;
      o_return_from_interrupt <= next_return;
      wait_cnt     <= next_done ? 3'(i_gap) + 3'h1 : wait_cnt - 3'h1;
      depth        <= depth + 2'(i_call_stb) - 2'(next_return);
      if (i_call_stb || next_return) begin
        isr_cnt <= 2'h0;
      end else if (next_done && depth != 2'h0 && isr_cnt != 2'h3) begin
        isr_cnt <= isr_cnt + 2'h1;
      end
    end
  end
endmodule

// >>> tb/interrupt_request_handler_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module interrupt_request_handler_test;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]           adr = 8'h00;
  logic [3:0]           sel = 4'h0;
  logic [31:0]          wdat = 32'h0, rdat;
  logic                 ack, done, return_from_interrupt, req, irq;
  logic [1:0]           pin = 2'h0, gap = 2'h0;
  logic [5:0]           ev = 6'h00;
  logic                 hold = 1'b1;
  irqh_pkg::irqh_call_t call;
  logic [31:0]          seed = 32'h8, q;
  int                   fail_count = 0, n_compared = 0, since_return = 0, reentry = 0, s, mpend = 0, e;
  int                   exp_q[$];

  always #25 clk = ~clk;

  irqh_ctrl u_irqh_ctrl (.I_REF_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_PIN_IRQ(pin),
    .I_PERIPH_EVENT(ev), .I_INSTR_DONE(done), .I_RETURN_FROM_INTERRUPT(return_from_interrupt),
    .O_CPU_REQ(req), .O_CALL(call), .O_IRQ(irq));
  irqh_cpu_model u_irqh_cpu_model (.i_clk(clk), .i_rst(rst), .i_call_stb(call.stb), .i_hold(hold),
    .i_gap(gap), .o_instr_done(done), .o_return_from_interrupt(return_from_interrupt));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  always @(posedge clk) gap <= 2'(rnd());

  // call monitor against the expected-call queue
  always @(posedge clk) begin
    if (call.stb === 1'b1) begin
      reentry = since_return;
      if (exp_q.size() == 0) begin
        `CHK(call.stb, 1'b0)
      end else begin
        e = exp_q.pop_front();
        `CHK(call.src, 3'(e / 2))
        `CHK(call.addr, 16'(3 + 8 * (e / 2)))
        `CHK(call.level, 1'(e % 2))
      end
    end
    if (return_from_interrupt === 1'b1) since_return = 0;
    else if (done === 1'b1) since_return++;
  end

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] x);
    wb(1'b0, a, 32'h0);
    `CHK(q, x)
  endtask

  task automatic expect_call(input int src, input int lvl);
    int n;
    exp_q.push_back(src * 2 + lvl);
    n = 0;
    while (exp_q.size() != 0 && n < 300) begin @(posedge clk); n++; end
    if (n >= 300) fail_count++;
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    chk_rd(irqh_pkg::OFF_INTERRUPT_ENABLE_REGISTER, 32'h0);
    chk_rd(irqh_pkg::OFF_PRIO, 32'h0);
    chk_rd(irqh_pkg::OFF_AUTO, 32'h3);
    chk_rd(irqh_pkg::OFF_STATE, 32'h1);
    chk_rd(8'h30, 32'h0);
    // random peripheral source raised while everything is off
    s = 2 + int'(rnd() % 6);
    ev <= 6'(1 << (s - 2));
    @(posedge clk) ev <= 6'h00;
    mpend |= 1 << s;
    chk_rd(irqh_pkg::OFF_PEND, 32'(mpend));
    wb(1'b1, irqh_pkg::OFF_EIE, 32'h1);
    wb(1'b1, irqh_pkg::OFF_INTERRUPT_ENABLE_REGISTER, 32'h7F);
    repeat (3) @(posedge clk);
    `CHK(req, 1'b0)
    // global on, every individual enable off
    wb(1'b1, irqh_pkg::OFF_EIE, 32'h0);
    wb(1'b1, irqh_pkg::OFF_INTERRUPT_ENABLE_REGISTER, 32'h80);
    repeat (3) @(posedge clk);
    `CHK(req, 1'b0)
    if (s == 7) wb(1'b1, irqh_pkg::OFF_EIE, 32'h1);
    else wb(1'b1, irqh_pkg::OFF_INTERRUPT_ENABLE_REGISTER, 32'h80 | 32'(1 << s));
    expect_call(s, 0);
    hold <= 1'b0;
    expect_call(s, 0);
    hold <= 1'b1;
    `CHK(reentry, 1)
    wb(1'b1, irqh_pkg::OFF_PCLR, 32'(1 << s));
    mpend = 0;
    hold <= 1'b0;
    repeat (40) @(posedge clk);
    // pin edge and software set on auto-clearing sources
    wb(1'b1, irqh_pkg::OFF_INTERRUPT_ENABLE_REGISTER, 32'h83);
    pin <= 2'h1;
    expect_call(0, 0);
    wb(1'b1, irqh_pkg::OFF_PEND, 32'h2);
    expect_call(1, 0);
    repeat (30) @(posedge clk);
    chk_rd(irqh_pkg::OFF_PEND, 32'(mpend));
    // order within a level, then high nests over low
    hold <= 1'b1;
    wb(1'b1, irqh_pkg::OFF_PRIO, 32'h20);
    wb(1'b1, irqh_pkg::OFF_INTERRUPT_ENABLE_REGISTER, 32'hFF);
    wb(1'b1, irqh_pkg::OFF_PEND, 32'h18);
    expect_call(3, 0);
    wb(1'b1, irqh_pkg::OFF_PEND, 32'h20);
    expect_call(5, 1);
    chk_rd(irqh_pkg::OFF_STATE, 32'h8);
    wb(1'b1, irqh_pkg::OFF_PCLR, 32'h38);
    hold <= 1'b0;
    repeat (60) @(posedge clk);
    chk_rd(irqh_pkg::OFF_STATE, 32'h1);
    // block interrupt: status, mask, clear
    chk_rd(irqh_pkg::OFF_ISTAT, 32'h7);
    `CHK(irq, 1'b0)
    wb(1'b1, irqh_pkg::OFF_IEN, 32'h1);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    wb(1'b1, irqh_pkg::OFF_ICLR, 32'h7);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    chk_rd(irqh_pkg::OFF_ISTAT, 32'h0);
    report_and_stop();
  end
endmodule
